// >>> rtl/arec_expiry_gate.v
// Expiry gate for asynchronous transmit response packets
`timescale 1ns/1ps
`include "arec_defs.vh"
// Summary of operation
// R1 - Software may put an expiry stamp in the first response descriptor.
// R2 - Stamp is 3-bit seconds plus 13-bit cycle number modulo 8000.
// R3 - Check stamp against cycle timer before each attempt and retry enters FIFO.
// R4 - Seconds difference is stamp seconds minus timer seconds, modulo eight.
// R5 - Seconds difference top bit set means late; reject packet.
// R6 - Top bit clear, lower bits nonzero means far future; send packet.
// R7 - Only a zero seconds difference falls through to cycle comparison.
// R8 - Cycle difference is signed 14-bit stamp minus timer cycle count.
// R9 - Zero or positive cycle difference lets the packet into the FIFO.
// R10 - Negative cycle difference rejects packet with timeout event code. A tx_complete in the same cycle overwrites it with tx_event.
// R11 - Passed packet is not rechecked while it waits or loads partly.
// R12 - Software should subtract worst-case FIFO delay from the stamp.
// R13 - Context has exactly a program pointer and a control/status register.
// R14 - Pointer gives program start; control register holds control and status.
// R15 - Completion or rejection writes low 16 control bits to result word.
// R16 - Timer seconds and cycle count are sampled in the same clock.
module arec_expiry_gate (
  input  wire        clk,              // 100 MHz clock
  input  wire        reset,            // Synchronous, active high
  input  wire        ptr_load,         // Load program pointer pulse
  input  wire [31:0] ptr_data,         // New program pointer value
  input  wire        ctrl_set,         // Set control bits pulse
  input  wire        ctrl_clear,       // Clear control bits pulse
  input  wire [15:0] ctrl_data,        // Mask for set or clear
  input  wire        check_req,        // Packet ready to enter FIFO, level
  input  wire [15:0] expiry_stamp,     // Seconds and cycle number of stamp
  input  wire        stamp_enable,     // Stamp present in descriptor
  input  wire [6:0]  bus_cycle_seconds,// Running timer seconds count
  input  wire [12:0] bus_cycle_count,  // Running timer cycle count
  input  wire        load_done,        // Whole packet now in FIFO, pulse
  input  wire        tx_complete,      // Link reports completion, pulse
  input  wire [4:0]  tx_event,         // Completion event code
  output reg         send_ok,          // Packet may load into FIFO, pulse
  output reg         reject,           // Packet expired, pulse
  output reg         status_wr,        // Result word write strobe, pulse
  output reg  [15:0] transfer_result_word, // Status for last descriptor
  output wire [31:0] program_pointer,  // Program start address
  output wire [15:0] ctrl_status       // Control and status readback
);

  // Gate states: idle looks at each attempt, held means a packet has
  // passed and waits in the FIFO, so its stamp is not looked at again
  localparam GATE_IDLE = 1'b0;
  localparam GATE_HELD = 1'b1;

  reg [31:0] program_pointer_reg;  // R13
  reg [31:0] program_pointer_next;
  reg [15:0] ctx_ctrl_status_reg;  // R13
  reg [15:0] ctx_ctrl_status_next;
  reg        state_reg;
  reg        state_next;

  // Seconds difference, modulo eight by the width of the result
  function [2:0] arec_sec_diff;
    input [2:0] stamp_sec;
    input [2:0] timer_sec;
    begin
      arec_sec_diff = stamp_sec - timer_sec;
    end
  endfunction

  // Sign bit prepended to both counts, so the top bit is the sign
  function [13:0] arec_cyc_diff;
    input [12:0] stamp_cyc;
    input [12:0] timer_cyc;
    begin
      arec_cyc_diff = {1'b0, stamp_cyc} - {1'b0, timer_cyc};
    end
  endfunction

  // Seconds decide first; the cycle count only breaks a tie
  function arec_is_late;
    input [2:0]  sdiff;
    input [13:0] cdiff;
    begin
      if (sdiff[2]) begin
        arec_is_late = 1'b1; // R5
      end else if (sdiff[1:0] != 2'b00) begin
        arec_is_late = 1'b0; // R6
      end else begin
        arec_is_late = cdiff[13]; // R7 R9 R10
      end
    end
  endfunction

  // Event code goes into the low field of the control word
  function [15:0] arec_put_event;
    input [15:0] word;
    input [4:0]  code;
    reg   [15:0] tmp;
    begin
      tmp = word;
      tmp[`AREC_EVT_LSB +: `AREC_EVT_W] = code;
      arec_put_event = tmp;
    end
  endfunction

  wire [2:0]  stamp_seconds_field;
  wire [12:0] stamp_cycle_number;
  wire [2:0]  now_sec;
  wire [2:0]  sec_diff;
  wire [13:0] cyc_diff;
  wire        late;
  wire        attempt;
  wire        expire_now;
  wire        pass_now;
  wire        result_now;

  assign stamp_seconds_field = expiry_stamp[`AREC_STAMP_SEC_LSB +: `AREC_SEC_W]; // R2
  assign stamp_cycle_number  = expiry_stamp[`AREC_STAMP_CYC_LSB +: `AREC_CYC_W]; // R2

  // Low seconds bits and cycle count come from one sample; a split read
  // across a second rollover would mis-order the pair.
  assign now_sec = bus_cycle_seconds[`AREC_SEC_W-1:0]; // R16

  assign sec_diff = arec_sec_diff(stamp_seconds_field, now_sec); // R4
  assign cyc_diff = arec_cyc_diff(stamp_cycle_number, bus_cycle_count); // R8

  // Without a stamp the packet never expires
  assign late = stamp_enable && arec_is_late(sec_diff, cyc_diff);

  // Only an idle gate takes an attempt; a retry comes as a new request
  assign attempt    = check_req && (state_reg == GATE_IDLE); // R3 R11
  assign expire_now = attempt && late;  // R5 R10
  assign pass_now   = attempt && !late; // R6 R9
  assign result_now = tx_complete || expire_now; // R15

  always @* begin
    state_next = state_reg;
    case (state_reg)
      GATE_IDLE: begin
        if (pass_now) begin
          state_next = GATE_HELD;
        end
      end
      GATE_HELD: begin
        // No recheck while held, the packet may be only partly loaded
        if (load_done || tx_complete) begin // R11
          state_next = GATE_IDLE;
        end
      end
      default: begin
        state_next = GATE_IDLE;
      end
    endcase
  end

  always @* begin
    program_pointer_next = program_pointer_reg;
    if (ptr_load) begin
      program_pointer_next = ptr_data; // R14
    end
  end

  // Clear applies after set when both arrive together
  always @* begin
    ctx_ctrl_status_next = ctx_ctrl_status_reg;
    if (ctrl_set) begin
      ctx_ctrl_status_next = ctx_ctrl_status_next | ctrl_data; // R14
    end
    if (ctrl_clear) begin
      ctx_ctrl_status_next = ctx_ctrl_status_next & ~ctrl_data; // R14
    end
    if (expire_now) begin
      ctx_ctrl_status_next = arec_put_event(ctx_ctrl_status_next, `AREC_EVT_TIMEOUT); // R10
    end
    if (tx_complete) begin
      ctx_ctrl_status_next = arec_put_event(ctx_ctrl_status_next, tx_event);
    end
    if (ctx_ctrl_status_next[`AREC_RUN_BIT] || (state_next == GATE_HELD)) begin
      ctx_ctrl_status_next[`AREC_ACTIVE_BIT] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_reg <= GATE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      program_pointer_reg <= `AREC_PTR_RESET;
      ctx_ctrl_status_reg <= `AREC_CTRL_RESET;
    end else begin
      program_pointer_reg <= program_pointer_next;
      ctx_ctrl_status_reg <= ctx_ctrl_status_next;
    end
  end

  // Decisions are registered so the FIFO side sees clean pulses
  always @(posedge clk) begin
    if (reset) begin
      send_ok   <= 1'b0;
      reject    <= 1'b0;
      status_wr <= 1'b0;
    end else begin
      send_ok   <= pass_now;   // R9
      reject    <= expire_now; // R5 R10
      status_wr <= result_now; // R15
    end
  end

  // Result word holds until the next completion or rejection
  always @(posedge clk) begin
    if (reset) begin
      transfer_result_word <= `AREC_RESULT_RESET;
    end else if (result_now) begin
      transfer_result_word <= ctx_ctrl_status_next; // R15
    end
  end

  assign program_pointer = program_pointer_reg;
  assign ctrl_status     = ctx_ctrl_status_reg;

  // Spare readback paths are left for the context's fetch logic; this
  // gate itself only needs the event field, the run bit and the active bit.

endmodule

// >>> rtl/arec_defs.vh
// Constants for the response expiry gate
`ifndef AREC_DEFS_VH
`define AREC_DEFS_VH
`define AREC_SEC_W          3
`define AREC_CYC_W          13
`define AREC_DIFF_W         14
`define AREC_CYC_MOD        13'h1f40
`define AREC_STAMP_CYC_LSB  0
`define AREC_STAMP_SEC_LSB  13
`define AREC_EVT_TIMEOUT    5'h0a
`define AREC_EVT_ACK_OK     5'h11
`define AREC_ACTIVE_BIT     10
`define AREC_RUN_BIT        15
`define AREC_PTR_RESET      32'h00000000
`define AREC_CTRL_RESET     16'h0000
`define AREC_RESULT_RESET   16'h0000
`define AREC_EVT_LSB        0
`define AREC_EVT_W          5
`endif

// >>> testbench/arec_chk.sv
// Assertions for the response expiry gate
`timescale 1ns/1ps
module arec_chk(input wire logic clk, reset, check_req, stamp_enable, send_ok, reject, status_wr,
  input wire logic [15:0] expiry_stamp, transfer_result_word,
  input wire logic [6:0] bus_cycle_seconds, input wire logic [12:0] bus_cycle_count);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire [2:0] sd = expiry_stamp[15:13] - bus_cycle_seconds[2:0];
  wire [13:0] cd = {1'b0, expiry_stamp[12:0]} - {1'b0, bus_cycle_count};
  wire late = stamp_enable && (sd[2] || (sd == 3'h0 && cd[13]));
  property p_rej; reject |-> $past(check_req && late); endproperty
  a_rej: assert property (p_rej) else $error("bad reject");
  property p_snd; send_ok |-> $past(check_req && !late); endproperty
  a_snd: assert property (p_snd) else $error("bad send");
  property p_ans; $rose(check_req) |=> send_ok || reject; endproperty
  a_ans: assert property (p_ans) else $error("no decision");
  property p_late; $rose(check_req) && late |=> reject; endproperty
  a_late: assert property (p_late) else $error("late sent");
  property p_one; send_ok |=> !send_ok; endproperty
  a_one: assert property (p_one) else $error("rechecked");
  property p_evt; reject |-> status_wr && transfer_result_word[4:0] == 5'h0a; endproperty
  a_evt: assert property (p_evt) else $error("bad status");
  property p_ex; !(send_ok && reject); endproperty
  a_ex: assert property (p_ex) else $error("both answers");
  property p_rst; $past(reset) |-> !send_ok && !reject && !status_wr; endproperty
  a_rst: assert property (p_rst) else $error("output after reset");
  cover property (reject);
  cover property (send_ok);
  cover property (send_ok ##1 check_req);
endmodule
bind arec_expiry_gate arec_chk i_chk(.clk(clk), .reset(reset), .check_req(check_req),
  .stamp_enable(stamp_enable), .send_ok(send_ok), .reject(reject), .status_wr(status_wr),
  .expiry_stamp(expiry_stamp), .transfer_result_word(transfer_result_word),
  .bus_cycle_seconds(bus_cycle_seconds), .bus_cycle_count(bus_cycle_count));

// >>> testbench/arec_fifo_model.sv
// Transmit FIFO and link stand-in
`timescale 1ns/1ps
module arec_fifo_model(input wire logic clk, reset, send_ok, input wire logic [3:0] delay,
  output logic load_done, tx_complete, output logic [4:0] tx_event);
  logic [4:0] cnt_reg;
  always @(posedge clk) begin
    load_done <= cnt_reg == 5'h02;
    tx_complete <= cnt_reg == 5'h01;
    // Code is only meaningful with completion
    tx_event <= reset ? 5'h00 : (cnt_reg == 5'h01) ? 5'h11 : ~tx_event;
    if (reset) cnt_reg <= 5'h00;
    else if (send_ok) cnt_reg <= {1'b0, delay} + 5'h02;
    else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the response expiry gate
`timescale 1ns/1ps
module testbench;
  logic clk = 0, reset = 1, check_req = 0, stamp_enable = 1, load_done, tx_complete;
  logic send_ok, reject, status_wr;
  logic [15:0] expiry_stamp = 16'h0000, word;
  logic [6:0] bus_cycle_seconds = 7'h00;
  logic [12:0] bus_cycle_count = 13'h0000;
  logic [3:0] delay = 4'h1;
  logic [4:0] tx_event;
  logic ptr_load = 0, ctrl_set = 0, ctrl_clear = 0;
  logic [31:0] ptr_data = 32'h0, ptr;
  logic [15:0] ctrl_data = 16'h0, ctrl;
  int err_total = 0, check_count = 0, cycles = 0;
  always #5 clk = ~clk;
  arec_expiry_gate i_arec_expiry_gate(.clk(clk), .reset(reset), .ptr_load(ptr_load),
    .ptr_data(ptr_data), .ctrl_set(ctrl_set), .ctrl_clear(ctrl_clear), .ctrl_data(ctrl_data),
    .check_req(check_req),
    .expiry_stamp(expiry_stamp), .stamp_enable(stamp_enable), .bus_cycle_seconds(bus_cycle_seconds),
    .bus_cycle_count(bus_cycle_count), .load_done(load_done), .tx_complete(tx_complete),
    .tx_event(tx_event), .send_ok(send_ok), .reject(reject), .status_wr(status_wr),
    .transfer_result_word(word), .program_pointer(ptr), .ctrl_status(ctrl));
  arec_fifo_model i_arec_fifo_model(.clk(clk), .reset(reset), .send_ok(send_ok), .delay(delay),
    .load_done(load_done), .tx_complete(tx_complete), .tx_event(tx_event));
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task miss(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task attempt(input logic en, input logic [15:0] st, input logic [6:0] sec,
    input logic [12:0] cyc, input logic rej);
    @(posedge clk);
    {stamp_enable, expiry_stamp, bus_cycle_seconds, bus_cycle_count, check_req} <= {en, st, sec, cyc, 1'b1};
    @(posedge clk);
    check_req <= 1'b0;
    #1 check_count++;
    if (reject !== rej || send_ok !== !rej || status_wr !== rej || (rej && (word[4:0] !== 5'h0a || ctrl[4:0] !== 5'h0a))) miss("decision");
    repeat (8) @(posedge clk);
  endtask
  task t_seconds;
    for (int d = 0; d < 8; d++) attempt(1'b1, {3'(5 + d), 13'h0}, 7'h45, 13'h1f3f, d[2] || d == 0);
  endtask
  task t_cycles;
    attempt(1'b1, 16'h0fa0, 7'h00, 13'h0f9f, 1'b0);
    attempt(1'b1, 16'h0fa0, 7'h00, 13'h0fa0, 1'b0);
    attempt(1'b1, 16'h0fa0, 7'h00, 13'h0fa1, 1'b1);
    attempt(1'b1, 16'h1000, 7'h08, 13'h0fff, 1'b0);
    attempt(1'b1, 16'h0000, 7'h00, 13'h1000, 1'b1);
    attempt(1'b0, 16'h0000, 7'h00, 13'h1f3f, 1'b0);
  endtask
  task t_hold;
    delay <= 4'h8;
    attempt(1'b1, 16'h0110, 7'h00, 13'h0100, 1'b0);
    repeat (4) @(posedge clk);
    {expiry_stamp, bus_cycle_count, check_req} <= {16'h0100, 13'h0100, 1'b1};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      bus_cycle_count <= 13'h0101;
      #1 check_count++;
      if (reject !== 1'b0 || send_ok !== (i == 0)) miss("recheck while waiting");
    end
    @(posedge clk);
    {check_req, delay} <= {1'b0, 4'h1};
    repeat (14) @(posedge clk);
  endtask
  task t_regs;
    @(posedge clk);
    {ptr_load, ptr_data, ctrl_set, ctrl_data} <= {1'b1, 32'h00012340, 1'b1, 16'h8000};
    @(posedge clk);
    {ptr_load, ctrl_set, ctrl_clear} <= 3'b001;
    #1 check_count++;
    if (ptr !== 32'h00012340 || ctrl[15] !== 1'b1 || ctrl[10] !== 1'b1) miss("pointer or control");
    @(posedge clk);
    ctrl_clear <= 1'b0;
    #1 check_count++;
    if (ctrl[15] !== 1'b0) miss("control clear");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_seconds;
    t_cycles;
    t_hold;
    t_regs;
    print_verdict;
  end
  always @(posedge clk) if (++cycles == 3000) begin miss("timeout"); print_verdict; end
endmodule
